// File: design/ddlc_dev.sv
/*
  DRAM-side timing logic: write leveling feedback, internal write start,
  auto-precharge recovery, power-down entry, short ZQ calibration, and an
  APB register slave. Assumes pins arrive asynchronously and are held
  by the controller long enough to pass the three-stage synchroniser.
*/
// Our own choices: the placing of the registers and register access over APB.
// Summary of operation
// - Leveling feedback appears on data lines within 7.5 ns of strobe edge; here DQ_O moves five clock edges after the pin edge.
// - All feedback data lines switch together, within 2 ns of each other.
// - Cycle spacings count actual clock edges, not averaged time.
// - Internal write starts WL+4 cycles, or WL+2 for fixed chop-of-four.
// - Memory accepts any long clock period while refresh interval holds.
// - Clock enable low accepted mid-operation; power-down waits for row, refresh and auto-precharge writes, not ZQ calibration.
// - Each short calibration completes within 64 clock cycles.
// - Write recovery cycles come from mode register 0 for auto-precharge.
module ddlc_dev import ddlc_pkg::*; #(
  parameter int AW = 8
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic CK_LVL,
  input wire logic DQS,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [2:0] BA,
  input wire logic [13:0] ADDR,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [7:0] DQ_O,
  output logic [7:0] DQ_OE_N,
  output logic WR_START,
  output logic PD_ACTIVE,
  output logic ZQ_BUSY
);
  logic [23:0] syn;
  ddlc_cmd_t cmd;
  logic ck_s;
  logic dqs_s;
  logic cke_s;
  logic dqs_d;
  logic cs_d;
  logic dqs_rise;
  logic cmd_take;
  ddlc_kind_t kind;

  // Idle-high pins enter inverted so a cleared stage reads idle after reset
  ddlc_sync #(.W(24)) u_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .d({CK_LVL, DQS, ~CKE, ~CS_N, ~RAS_N, ~CAS_N, ~WE_N, BA, ADDR}),
    .q(syn)
  );

  assign cmd = {~syn[20:17], syn[16:0]};
  assign ck_s = syn[23];
  assign dqs_s = syn[22];
  assign cke_s = ~syn[21];
  assign dqs_rise = dqs_s & ~dqs_d;
  // One command per chip-select falling edge
  assign cmd_take = ~cmd.cs_n & cs_d;
  assign kind = cmd_take ? ddlc_decode(cmd) : K_NOP;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dqs_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      dqs_d <= dqs_s;
      cs_d <= cmd.cs_n;
    end
  end

  // Mode registers
  logic [2:0] wr_code;
  logic [1:0] bl_mode;
  logic wl_en;
  logic chop_fixed;
  assign chop_fixed = (bl_mode == BL_CHOP_FIXED);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wr_code <= WR_CODE_RST;
      bl_mode <= 2'h0;
      wl_en <= 1'b0;
    end else if (kind == K_MRS) begin
      if (cmd.ba == 3'h0) begin
        wr_code <= cmd.addr[MR_WR_LSB +: 3];
        bl_mode <= cmd.addr[1:0];
      end else if (cmd.ba == 3'h1) begin
        wl_en <= cmd.addr[MR_WL_BIT];
      end
    end
  end

  // Software configuration
  logic [31:0] cfg;
  logic [4:0] cwl;
  logic [7:0] row_cyc;
  logic [7:0] ref_cyc;
  assign cwl = {1'b0, cfg[CFG_CWL_LSB +: 4]};
  assign row_cyc = {4'h0, cfg[CFG_ROW_LSB +: 4]};
  assign ref_cyc = cfg[CFG_REF_LSB +: 8];

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      DQ_O <= 8'h00;
    end else if (wl_en && dqs_rise) begin
      DQ_O <= {8{ck_s}};
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      DQ_OE_N <= 8'hff;
    end else begin
      DQ_OE_N <= {8{~wl_en}};
    end
  end

  // Write path; a new write restarts a pending one
  logic [4:0] wr_cnt;
  logic ap_pend;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wr_cnt <= 5'h00;
      ap_pend <= 1'b0;
    end else if (kind == K_WR) begin
      wr_cnt <= cwl + (chop_fixed ? WRS_CHOP : WRS_FULL);
      ap_pend <= cmd.addr[ADDR_AP_BIT];
    end else if (wr_cnt != 5'h00) begin
      wr_cnt <= wr_cnt - 5'h01;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      WR_START <= 1'b0;
    end else begin
      // Registered, so launched one count early to stand in cycle D
      WR_START <= (wr_cnt == 5'h02) && (kind != K_WR);
    end
  end

  // Auto-precharge recovery
  logic [4:0] ap_cnt;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ap_cnt <= 5'h00;
    end else if (WR_START && ap_pend) begin
      ap_cnt <= ddlc_wr_cycles(wr_code);
    end else if (ap_cnt != 5'h00) begin
      ap_cnt <= ap_cnt - 5'h01;
    end
  end

  // Row activation, precharge and refresh in progress
  logic [7:0] op_cnt;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      op_cnt <= 8'h00;
    end else if (kind == K_ACT || kind == K_PRE) begin
      op_cnt <= row_cyc;
    end else if (kind == K_REF) begin
      op_cnt <= ref_cyc;
    end else if (op_cnt != 8'h00) begin
      op_cnt <= op_cnt - 8'h01;
    end
  end

  logic busy;
  assign busy = (op_cnt != 8'h00) || (ap_cnt != 5'h00) ||
                (ap_pend && (wr_cnt != 5'h00 || WR_START));

  // Power-down sequencing
  ddlc_pd_t pd_state;
  ddlc_pd_t next_pd;
  always_comb begin
    next_pd = pd_state;
    case (pd_state)
      PS_RUN: begin
        if (!cke_s) begin
          next_pd = busy ? PS_WAIT : PS_DOWN;
        end
      end
      PS_WAIT: begin
        if (cke_s) begin
          next_pd = PS_RUN;
        end else if (!busy) begin
          next_pd = PS_DOWN;
        end
      end
      // no timeout on a stopped clock
      PS_DOWN: begin
        if (cke_s) begin
          next_pd = PS_RUN;
        end
      end
      default: next_pd = PS_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pd_state <= PS_RUN;
      PD_ACTIVE <= 1'b0;
    end else begin
      pd_state <= next_pd;
      PD_ACTIVE <= (next_pd == PS_DOWN);
    end
  end

  // Short calibration; a second request while busy is dropped
  logic [6:0] zq_cnt;
  logic [15:0] zq_done;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      zq_cnt <= 7'h00;
      zq_done <= 16'h0000;
      ZQ_BUSY <= 1'b0;
    end else begin
      if (kind == K_ZQ && !cmd.addr[ADDR_AP_BIT] && zq_cnt == 7'h00) begin
        zq_cnt <= 7'(ZQCS_NCK);
        ZQ_BUSY <= 1'b1;
      end else if (zq_cnt != 7'h00) begin
        zq_cnt <= zq_cnt - 7'h01;
        ZQ_BUSY <= (zq_cnt != 7'h01);
      end
      if (zq_cnt == 7'h01) begin
        zq_done <= zq_done + 16'h0001;
      end
    end
  end

  // APB slave: no wait states, read data captured in setup
  logic setup;
  logic access;
  logic hit;
  logic [31:0] rd_val;
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE && PREADY;
  assign hit = (PADDR[7:0] == OFS_CFG) || (PADDR[7:0] == OFS_STAT) ||
               (PADDR[7:0] == OFS_ZQN);

  always_comb begin
    rd_val = 32'h0000_0000;
    case (PADDR[7:0])
      OFS_CFG: rd_val = cfg;
      OFS_STAT: begin
        rd_val[ST_WL] = wl_en;
        rd_val[ST_PD] = PD_ACTIVE;
        rd_val[ST_ZQ] = ZQ_BUSY;
        rd_val[ST_BUSY] = busy;
        rd_val[ST_WR_LSB +: 3] = wr_code;
        rd_val[ST_CHOP] = chop_fixed;
      end
      OFS_ZQN: rd_val = {16'h0000, zq_done};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !hit;
      if (setup) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_val;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cfg <= CFG_RST;
    end else if (access && PWRITE && PADDR[7:0] == OFS_CFG) begin
      cfg <= PWDATA;
    end
  end

  // Helpers for timing checks
  logic [5:0] since_wr;
  logic [4:0] exp_d;
  logic [6:0] zq_len;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      since_wr <= 6'h00;
      exp_d <= 5'h00;
      zq_len <= 7'h00;
    end else begin
      if (kind == K_WR) begin
        since_wr <= 6'h01;
        exp_d <= cwl + (chop_fixed ? WRS_CHOP : WRS_FULL);
      end else if (since_wr != 6'h3f) begin
        since_wr <= since_wr + 6'h01;
      end
      zq_len <= ZQ_BUSY ? zq_len + 7'h01 : 7'h00;
    end
  end

  a_wl_sample: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    wl_en && dqs_rise |=> DQ_O == {8{$past(ck_s)}})
    else $error("leveling feedback wrong");

  a_wlo_quiet: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    !dqs_rise |=> $stable(DQ_O))
    else $error("feedback moved without strobe");

  a_fb_skew: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    DQ_OE_N != 8'hff |-> DQ_OE_N == 8'h00 && DQ_O == {8{DQ_O[0]}})
    else $error("feedback lanes disagree");

  a_wr_start_time: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    WR_START |-> {1'b0, since_wr} == {2'b00, exp_d})
    else $error("internal write start mistimed");

  a_edge_count: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    wr_cnt != 5'h00 && kind != K_WR |=> wr_cnt == $past(wr_cnt) - 5'h01)
    else $error("write counter skipped");

  a_pd_wait: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    pd_state == PS_WAIT && busy && !cke_s |=> !PD_ACTIVE)
    else $error("power-down before completion");

  a_pd_enter: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    pd_state == PS_WAIT && !busy && !cke_s |=> PD_ACTIVE)
    else $error("power-down not entered");

  a_pd_hold: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    PD_ACTIVE && !cke_s |=> PD_ACTIVE ##1 PD_ACTIVE || cke_s)
    else $error("power-down left on its own");

  a_zq_bound: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    $fell(ZQ_BUSY) |-> $past(zq_len) == 7'(ZQCS_NCK - 1))
    else $error("calibration length wrong");

  a_ap_load: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    WR_START && ap_pend |=> ap_cnt == ddlc_wr_cycles($past(wr_code)))
    else $error("recovery count not from mode register");

  a_apb_ready: assert property (
    @(posedge SYS_CLK) disable iff (RST)
    PSEL && !PENABLE |=> PREADY ##1 !PREADY || (PSEL && !PENABLE))
    else $error("apb ready timing");
endmodule

// File: pkg/ddlc_pkg.sv
/*
  Shared constants, types and helpers for the DRAM-side timing block:
  register map, mode register fields, timing counts, command decode.
  Assumes a 25 MHz system clock; WLO_CYC is derived from that rate.
*/
package ddlc_pkg;

  // Clock and timing
  localparam int CLK_PS = 40000;
  localparam int T_WLO_PS = 7500;
  localparam int WLO_RAW = T_WLO_PS / CLK_PS;
  localparam int WLO_CYC = (WLO_RAW < 1) ? 1 : WLO_RAW;
  localparam int ZQCS_NCK = 64;
  localparam logic [4:0] WRS_FULL = 5'h04;
  localparam logic [4:0] WRS_CHOP = 5'h02;

  // Register offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ZQN = 8'h08;

  // Configuration fields and reset value
  localparam int CFG_CWL_LSB = 0;
  localparam int CFG_ROW_LSB = 8;
  localparam int CFG_REF_LSB = 16;
  localparam logic [31:0] CFG_RST = 32'h0010_0405;

  // Status fields
  localparam int ST_WL = 0;
  localparam int ST_PD = 1;
  localparam int ST_ZQ = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_WR_LSB = 4;
  localparam int ST_CHOP = 7;

  // Mode register fields
  localparam int MR_WR_LSB = 9;
  localparam int MR_WL_BIT = 7;
  localparam int ADDR_AP_BIT = 10;
  localparam logic [1:0] BL_CHOP_FIXED = 2'h2;
  localparam logic [2:0] WR_CODE_RST = 3'h1;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
  } ddlc_cmd_t;

  typedef enum logic [2:0] {
    K_MRS = 3'b000,
    K_REF = 3'b001,
    K_PRE = 3'b010,
    K_ACT = 3'b011,
    K_WR = 3'b100,
    K_RD = 3'b101,
    K_ZQ = 3'b110,
    K_NOP = 3'b111
  } ddlc_kind_t;

  typedef enum logic [1:0] {
    PS_RUN = 2'b00,
    PS_WAIT = 2'b01,
    PS_DOWN = 2'b10
  } ddlc_pd_t;

  function automatic ddlc_kind_t ddlc_decode(input ddlc_cmd_t c);
    ddlc_kind_t k;
    k = ddlc_kind_t'({c.ras_n, c.cas_n, c.we_n});
    return k;
  endfunction

  // Write recovery code to clock cycles
  function automatic logic [4:0] ddlc_wr_cycles(input logic [2:0] code);
    logic [4:0] n;
    case (code)
      3'h1: n = 5'h05;
      3'h2: n = 5'h06;
      3'h3: n = 5'h07;
      3'h4: n = 5'h08;
      3'h5: n = 5'h0a;
      3'h6: n = 5'h0c;
      3'h7: n = 5'h0e;
      default: n = 5'h10;
    endcase
    return n;
  endfunction

endpackage

// File: design/ddlc_sync.sv
/*
  Three-stage input synchroniser with per-bit agreement filter.
  Assumes inputs come from outside the SYS_CLK domain.
*/
module ddlc_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit moves only when stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & q);
    end
  end
endmodule

// File: test/ddlc_ctl_model.sv
/*
  Behavioural memory controller driving the memory-side pins of ddlc_dev.
  Assumes its tasks are called from one bench process, just after an edge.
*/
module ddlc_ctl_model import ddlc_pkg::*; (
  input wire logic clk,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [13:0] addr,
  output logic dqs,
  output logic ck_lvl,
  output logic cke
);
  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 3'h0;
    addr = 14'h0;
    dqs = 1'b0;
    ck_lvl = 1'b0;
    cke = 1'b1;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic cmd(input ddlc_kind_t k, input logic [2:0] b,
                     input logic [13:0] a);
    {ras_n, cas_n, we_n} <= k;
    ba <= b;
    addr <= a;
    idle(4);
    cs_n <= ~cs_n;
    idle(4);
    cs_n <= ~cs_n;
    idle(4);
    // Released bus must not keep showing the old bank and address
    ba <= ~b;
    addr <= ~a;
    idle(1);
  endtask

  // strobe held off after leveling entry
  task automatic level_on();
    cmd(K_MRS, 3'h1, 14'h0080);
    idle(40);
  endtask

  task automatic level_pulse(input logic ck);
    ck_lvl <= ck;
    idle(2);
    dqs <= ~dqs;
    idle(6);
    dqs <= ~dqs;
    idle(4);
  endtask

  task automatic set_cke(input logic v);
    cke <= v;
    idle(1);
  endtask
endmodule

// File: test/ddr3_leveling_command_timing_tb_top.sv
/*
  Self-checking bench for ddlc_dev with a controller model on its pins.
  Assumes pins reach the logic four edges late and the design's APB timing.
*/
module ddr3_leveling_command_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ddlc_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, dq_o, dq_oe_n;
  logic [31:0] pwdata, prdata, cfg_m;
  logic wr_start, pd_active, zq_busy, ck_lvl, dqs, cke;
  logic cs_n, ras_n, cas_n, we_n, cs_q;
  logic [2:0] ba;
  logic [13:0] addr;
  int miscompares, num_checks, since, zq_len, seed;
  int exp_q[$];

  ddlc_dev uut (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .CK_LVL(ck_lvl), .DQS(dqs), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
    .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n),
    .WR_START(wr_start), .PD_ACTIVE(pd_active), .ZQ_BUSY(zq_busy));

  ddlc_ctl_model ctl (.clk(sys_clk), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqs(dqs),
    .ck_lvl(ck_lvl), .cke(cke));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No timeout here; only the watchdog ends this wait if PREADY never rises
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Edges from the pin-level command strobe; write starts pop the model
  always @(posedge sys_clk) begin
    cs_q <= cs_n;
    since <= (cs_q === 1'b1 && cs_n === 1'b0) ? 1 : since + 1;
    if (zq_busy === 1'b1)
      zq_len <= zq_len + 1;
    if (wr_start === 1'b1) begin
      if (exp_q.size() > 0)
        check("wr_start delay", 32'(since), 32'(exp_q.pop_front()));
      else
        check("wr_start spurious", 32'h1, 32'h0);
    end
  end

  initial begin
    #(40 * 30000);
    miscompares++;
    conclude();
  end

  initial begin
    logic [31:0] q;
    logic e, ck;
    int cwl, d;
    seed = 45410;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    zq_len = 0;
    since = 0;
    rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("oe after reset", 32'(dq_oe_n), 32'hff);
    check("pd after reset", 32'(pd_active), 32'h0);
    apb(1'b0, OFS_STAT, 32'h0, q, e);
    check("stat reset", q, {24'h0, 1'b0, WR_CODE_RST, 4'h0});
    apb(1'b0, OFS_CFG, 32'h0, q, e);
    check("cfg reset", q, CFG_RST);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    check("unmapped err", 32'(e), 32'h1);
    check("unmapped data", q, 32'h0);
    cwl = 5 + {$random(seed)} % 6;
    cfg_m = {8'h00, 8'h40, 8'h04, 4'h0, 4'(cwl)};
    apb(1'b1, OFS_CFG, cfg_m, q, e);
    apb(1'b0, OFS_CFG, 32'h0, q, e);
    check("cfg rw", q, cfg_m);
    $display("done registers");
    for (int c = 0; c < 8; c++) begin
      ctl.cmd(K_MRS, 3'h0, 14'(c << MR_WR_LSB));
      apb(1'b0, OFS_STAT, 32'h0, q, e);
      check("wr code", 32'(q[6:4]), 32'(c));
    end
    for (int k = 0; k < 2; k++) begin
      ctl.cmd(K_MRS, 3'h0, 14'((1 << MR_WR_LSB) | (k * 2)));
      exp_q.push_back(4 + cwl + (k == 1 ? 2 : 4));
      ctl.cmd(K_WR, 3'h0, 14'({$random(seed)} & 32'h3bff));
      ctl.idle(20);
      check("wr pending", 32'(exp_q.size()), 32'h0);
    end
    $display("done write start");
    ctl.level_on();
    check("oe leveling", 32'(dq_oe_n), 32'h0);
    repeat (4) begin
      ck = 1'($random(seed));
      ctl.level_pulse(ck);
      check("feedback", 32'(dq_o), 32'({8{ck}}));
    end
    ctl.cmd(K_MRS, 3'h1, 14'h0);
    ctl.idle(4);
    check("oe off", 32'(dq_oe_n), 32'hff);
    $display("done leveling");
    ctl.cmd(K_ZQ, 3'h0, 14'h0);
    ctl.cmd(K_ZQ, 3'h0, 14'h0);
    ctl.idle(80);
    check("zq length", 32'(zq_len), 32'd64);
    apb(1'b0, OFS_ZQN, 32'h0, q, e);
    check("zq count", q, 32'h1);
    $display("done calibration");
    ctl.cmd(K_REF, 3'h0, 14'h0);
    ctl.set_cke(1'b0);
    d = 0;
    while (pd_active !== 1'b1 && d < 200) begin
      @(posedge sys_clk);
      d++;
    end
    check("pd after refresh", 32'(d >= 40 && d <= 70), 32'h1);
    apb(1'b0, OFS_STAT, 32'h0, q, e);
    check("stat pd", 32'(q[1]), 32'h1);
    ctl.set_cke(1'b1);
    ctl.idle(8);
    check("pd exit", 32'(pd_active), 32'h0);
    $display("done power-down");
    conclude();
  end
endmodule
